// ### respiration_control_defs.svh
// Register indices, field positions, reset values and timing figures for the excitation block
`ifndef RESPIRATION_CONTROL_DEFS_SVH
`define RESPIRATION_CONTROL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map (indices; byte address is four times the index)
// ----------------------------------------------------------------------------
`define RESPIRATION_CONTROL_IDX 8'h16
`define CFG4_IDX 8'h17
`define REG_W 8
`define REG_RST 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DEMOD_EN_BIT 7
`define MOD_EN_BIT 6
`define PH_MSB 4
`define PH_LSB 2
`define MODE_MSB 1
`define MODE_LSB 0
`define FREQ_MSB 7
`define FREQ_LSB 5

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define FREQ_32K 3'h1
`define PH_UNDEF 3'h7
`define PH_STEP_BITS 4
`define PINS_RELEASED 3'h7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ 20000000
`define MOD_BASE_HZ 64000

`endif

// ### respiration_control_pkg.sv
// Types shared by the excitation control block
package respiration_control_pkg;

	// ----------------------------------------------------------------------------
	// Breathing mode codes
	// ----------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_EXT = 2'h1,
		MODE_INT_USER = 2'h3,
		MODE_INT = 2'h2
	} breathing_mode_t;

	// ----------------------------------------------------------------------------
	// Registered state of the top module, apart from the half-period monitor and the tone generator
	// ----------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] respiration_control;
		logic [7:0] cfg4;
		logic [7:0] rdata;
		logic mod_clk;
		logic demod_clk;
		logic drive_pos;
		logic drive_neg;
		logic [2:0] pin_out;
		logic [2:0] pin_oe_n;
		logic [2:0] level;
	} ctrl_state_t;

endpackage

// ### respiration_control_tone_gen.sv
// Phase accumulator that makes the excitation wave and its phase-shifted copy
`timescale 1ns/10ps
`include "respiration_control_defs.svh"

module respiration_control_tone_gen
	import respiration_control_pkg::*;
#(
	parameter int ACC_W = 32,
	parameter int CLK_HZ = `CLK_HZ,
	parameter int BASE_HZ = `MOD_BASE_HZ
) (
	input logic pclk,
	input logic presetn,
	input logic [2:0] freq_sel,
	input logic [2:0] phase_sel,
	input logic phase_apply,
	output logic ref_wave,
	output logic lag_wave
);

	// ----------------------------------------------------------------------------
	// Increment for the top setting; each step down halves it
	// ----------------------------------------------------------------------------
	localparam longint unsigned inc_wide = (longint'(BASE_HZ) << ACC_W) / longint'(CLK_HZ);
	localparam logic [ACC_W-1:0] inc_base = inc_wide[ACC_W-1:0];

	if (ACC_W < 16 || ACC_W > 32 || BASE_HZ * 2 >= CLK_HZ) begin : g_bad_cfg
		$error("respiration_control_tone_gen: accumulator width or rates out of range");
	end

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic ref_q;
		logic lag_q;
	} tone_state_t;

	tone_state_t st;
	tone_state_t nxt;
	logic [ACC_W-1:0] inc;
	logic [ACC_W-1:0] offset;
	logic [ACC_W-1:0] lag_acc;
	logic [3:0] ph_steps;

	// Next accumulator and both wave bits; waves taken from the next value
	always_comb begin
		nxt = st;
		inc = inc_base >> freq_sel;
		ph_steps = {1'b0, phase_sel} + 4'h1;
		// A 1/16 turn is 22.5 degrees, so the lag is (code+1) sixteenths
		offset = phase_apply ? {ph_steps, {(ACC_W - `PH_STEP_BITS){1'b0}}} : '0;
		nxt.acc = st.acc + inc;
		lag_acc = nxt.acc - offset;
		nxt.ref_q = nxt.acc[ACC_W-1];
		nxt.lag_q = lag_acc[ACC_W-1];
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= nxt;
		end
	end

	assign ref_wave = st.ref_q;
	assign lag_wave = st.lag_q;

	// ----------------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------------
	// First edge after release has no step yet, so the previous edge must be out of reset
	a_step_halving: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> st.acc == $past(st.acc) + (inc_base >> $past(freq_sel)))
		else $error("accumulator step does not halve with the setting");

endmodule

// ### respiration_excitation_ctrl.sv
// APB register bank and excitation timing for the breathing impedance function
//
// How it works
// - Control bit 7 switches the channel 1 demodulation output on or off.
// - Control bit 6 switches the channel 1 modulation output on or off.
// - Phase field lags demodulation by 22.5 degree steps in modes 01 and 10; code 111 is undefined.
// - Mode field picks none, external, internal, or internal with user signals.
// - Frequency field steers the waveform while mode is internal with internal signals.
// - Frequency codes 000 and 001 give a 64 kHz or 32 kHz modulation clock.
// - Codes 010 to 111 give square waves on pins 3 and 4, 16 kHz to 500 Hz.
// - Pin 4 carries the inverse of pin 3 while a square wave runs.
// - Control register sits at index 16h and resets to zero.
// - Fourth configuration register sits at index 17h and resets to zero.
// - Modes 01 and 11 withhold pins 2, 3 and 4 from general-purpose use.
`timescale 1ns/10ps
`include "respiration_control_defs.svh"

module respiration_excitation_ctrl
	import respiration_control_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int ACC_W = 32
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [2:0] gp_is_input,
	input logic [2:0] gp_data,
	input logic aux_pin_2_in,
	output logic aux_pin_2_out,
	output logic aux_pin_2_oe_n,
	input logic aux_pin_3_in,
	output logic aux_pin_3_out,
	output logic aux_pin_3_oe_n,
	input logic aux_pin_4_in,
	output logic aux_pin_4_out,
	output logic aux_pin_4_oe_n,
	output logic [2:0] gp_level,
	output logic gpio_pins_free,
	output logic demod_enable_ch1,
	output logic mod_enable_ch1,
	output logic mod_clk,
	output logic demod_clk,
	output logic mod_drive_pos,
	output logic mod_drive_neg
);

	// ----------------------------------------------------------------------------
	// Constants and elaboration check
	// ----------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] respiration_control_addr = ADDR_W'(`RESPIRATION_CONTROL_IDX * 4);
	localparam logic [ADDR_W-1:0] cfg4_addr = ADDR_W'(`CFG4_IDX * 4);
	localparam int half_64k = `CLK_HZ / (2 * `MOD_BASE_HZ);
	localparam int half_min = half_64k - 2;
	localparam int half_max = half_64k + 1;
	localparam int half32_min = 2 * half_64k - 2;
	localparam int half32_max = 2 * half_64k + 2;
	localparam ctrl_state_t st_rst = '{
		respiration_control: `REG_RST,
		cfg4: `REG_RST,
		rdata: `REG_RST,
		pin_oe_n: `PINS_RELEASED,
		default: '0
	};

	if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
		$error("respiration_excitation_ctrl: address width cannot hold the map");
	end

	// ----------------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------------
	ctrl_state_t st;
	ctrl_state_t nxt;
	breathing_mode_t mode;
	logic [2:0] freq;
	logic [2:0] phase;
	logic demod_on;
	logic mod_on;
	logic clock_path;
	logic square_act;
	logic internal;
	logic withheld;
	logic phase_apply;
	logic hit_respiration_control;
	logic hit_cfg4;
	logic rd_setup;
	logic wr_access;
	logic ref_wave;
	logic lag_wave;
	logic [2:0] pin_in;

	// Field decode from the stored registers
	assign mode = breathing_mode_t'(st.respiration_control[`MODE_MSB:`MODE_LSB]);
	assign freq = st.cfg4[`FREQ_MSB:`FREQ_LSB];
	assign phase = st.respiration_control[`PH_MSB:`PH_LSB];
	assign demod_on = st.respiration_control[`DEMOD_EN_BIT];
	assign mod_on = st.respiration_control[`MOD_EN_BIT];
	assign clock_path = (freq <= `FREQ_32K);
	assign square_act = !clock_path && (mode == MODE_INT);
	assign internal = (mode == MODE_INT) || (mode == MODE_INT_USER);
	assign withheld = (mode == MODE_EXT) || (mode == MODE_INT_USER);
	assign phase_apply = clock_path && ((mode == MODE_EXT) || (mode == MODE_INT));
	assign pin_in = {aux_pin_4_in, aux_pin_3_in, aux_pin_2_in};

	// ----------------------------------------------------------------------------
	// APB slave decode
	// ----------------------------------------------------------------------------
	// Zero-wait slave; read data is latched in setup so prdata comes from a flop
	assign hit_respiration_control = (paddr == respiration_control_addr);
	assign hit_cfg4 = (paddr == cfg4_addr);
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_access = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_respiration_control && !hit_cfg4;

	// ----------------------------------------------------------------------------
	// Wave source
	// ----------------------------------------------------------------------------
	respiration_control_tone_gen #(
		.ACC_W(ACC_W),
		.CLK_HZ(`CLK_HZ),
		.BASE_HZ(`MOD_BASE_HZ)
	) u_tone (
		.pclk(pclk),
		.presetn(presetn),
		.freq_sel(freq),
		.phase_sel(phase),
		.phase_apply(phase_apply),
		.ref_wave(ref_wave),
		.lag_wave(lag_wave)
	);

	// Next state: register writes, read capture, excitation and pin muxing
	always_comb begin
		nxt = st;
		if (wr_access && hit_respiration_control) begin
			nxt.respiration_control = pwdata[`REG_W-1:0];
		end
		if (wr_access && hit_cfg4) begin
			nxt.cfg4 = pwdata[`REG_W-1:0];
		end
		if (rd_setup) begin
			nxt.rdata = hit_respiration_control ? st.respiration_control : (hit_cfg4 ? st.cfg4 : `REG_RST);
		end
		// Clocks idle low when gated; the gate acts at once, so a high phase can be cut short
		nxt.mod_clk = mod_on && (mode != MODE_NONE) && clock_path && ref_wave;
		nxt.demod_clk = demod_on && (mode != MODE_NONE) && clock_path
			&& (phase != `PH_UNDEF) && lag_wave;
		nxt.drive_pos = mod_on && internal && clock_path && ref_wave;
		nxt.drive_neg = mod_on && internal && clock_path && !ref_wave;
		for (int i = 0; i < 3; i++) begin
			if (square_act && (i != 0)) begin
				nxt.pin_oe_n[i] = 1'b0;
				nxt.pin_out[i] = (i == 1) ? ref_wave : !ref_wave;
			end else if (withheld) begin
				nxt.pin_oe_n[i] = 1'b1;
				nxt.pin_out[i] = 1'b0;
			end else begin
				nxt.pin_oe_n[i] = gp_is_input[i];
				nxt.pin_out[i] = gp_data[i];
			end
			nxt.level[i] = !withheld && pin_in[i];
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= st_rst;
		end else begin
			st <= nxt;
		end
	end

	// ----------------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------------
	assign prdata = {{(32 - `REG_W){1'b0}}, st.rdata};
	assign aux_pin_2_out = st.pin_out[0];
	assign aux_pin_2_oe_n = st.pin_oe_n[0];
	assign aux_pin_3_out = st.pin_out[1];
	assign aux_pin_3_oe_n = st.pin_oe_n[1];
	assign aux_pin_4_out = st.pin_out[2];
	assign aux_pin_4_oe_n = st.pin_oe_n[2];
	assign gp_level = st.level;
	assign gpio_pins_free = !withheld;
	assign demod_enable_ch1 = demod_on;
	assign mod_enable_ch1 = mod_on;
	assign mod_clk = st.mod_clk;
	assign demod_clk = st.demod_clk;
	assign mod_drive_pos = st.drive_pos;
	assign mod_drive_neg = st.drive_neg;

	// ----------------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Half-period monitor; restarts whenever either register changes
	logic [9:0] half_cnt;
	logic [1:0] tog_seen;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= '0;
			tog_seen <= '0;
		end else if (nxt.respiration_control != st.respiration_control || nxt.cfg4 != st.cfg4) begin
			half_cnt <= '0;
			tog_seen <= '0;
		end else if (nxt.mod_clk != st.mod_clk) begin
			half_cnt <= '0;
			tog_seen <= (tog_seen == 2'h3) ? tog_seen : tog_seen + 2'h1;
		end else begin
			half_cnt <= half_cnt + 10'h1;
		end
	end

	a_demod_off: assert property ($fell(demod_on) |=> !demod_clk [*4])
		else $error("demodulation clock runs while disabled");
	a_mod_off: assert property (!mod_on |=> !mod_clk && !mod_drive_pos && !mod_drive_neg)
		else $error("modulation output runs while disabled");
	a_phase_undef: assert property ((phase == `PH_UNDEF) |=> !demod_clk)
		else $error("demodulation clock runs with undefined phase");
	a_mode_none: assert property ((mode == MODE_NONE) |=> !mod_clk && !demod_clk)
		else $error("clocks run with breathing mode off");
	a_freq_scope: assert property (!clock_path && mode != MODE_INT
		|=> !mod_clk && (aux_pin_3_oe_n == $past(withheld || gp_is_input[1])))
		else $error("square setting acts outside internal mode");
	// Judged at the edge that launches the toggle, while half_cnt still holds the interval
	a_mod_period: assert property ((nxt.mod_clk != st.mod_clk) && tog_seen != 2'h0
		&& nxt.respiration_control == st.respiration_control && nxt.cfg4 == st.cfg4
		|-> (freq == `FREQ_32K) ? (half_cnt >= half32_min && half_cnt <= half32_max)
			: (half_cnt >= half_min && half_cnt <= half_max))
		else $error("modulation clock half period off");
	a_square_drive: assert property (square_act |=> !aux_pin_3_oe_n && !aux_pin_4_oe_n)
		else $error("square wave not driven on pins 3 and 4");
	a_pin4_inverse: assert property ($past(square_act) |-> aux_pin_4_out != aux_pin_3_out)
		else $error("pin 4 is not the inverse of pin 3");
	a_drive_pair: assert property ($past(mod_on && internal && clock_path)
		|-> (mod_drive_pos != mod_drive_neg) && (mod_drive_pos == mod_clk))
		else $error("modulation terminals not complementary");
	a_respiration_control_write: assert property (wr_access && hit_respiration_control |=> st.respiration_control == $past(pwdata[7:0]))
		else $error("control register write lost");
	a_cfg4_write: assert property (wr_access && hit_cfg4 |=> st.cfg4 == $past(pwdata[7:0]))
		else $error("configuration register write lost");
	a_pins_withheld: assert property (withheld |=> aux_pin_2_oe_n && aux_pin_3_oe_n
		&& aux_pin_4_oe_n && gp_level == 3'h0)
		else $error("withheld pins still in general use");
	a_wave_priority: assert property (square_act && gp_is_input[1] |=> !aux_pin_3_oe_n)
		else $error("general-purpose direction beat the square wave");

	c_square_run: cover property (square_act ##1 $rose(aux_pin_3_out));
	c_int_mod: cover property (mode == MODE_INT && clock_path && mod_on ##1 $rose(mod_clk));
	c_ext_demod: cover property (mode == MODE_EXT && demod_on ##1 $rose(demod_clk));
	c_bad_addr: cover property (pslverr);

endmodule

// ### respiration_excitation_ctrl_test.sv
// Self-checking bench for the breathing excitation register bank
`timescale 1ns/10ps

module respiration_excitation_ctrl_test;
	// ----------------------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [2:0] gp_is_input = 3'h7;
	logic [2:0] gp_data = 3'h0;
	logic [2:0] ext_lvl = 3'h0;
	logic [2:0] pin_out, pin_oe_n, gp_level;
	logic gpio_pins_free, demod_enable_ch1, mod_enable_ch1;
	logic mod_clk, demod_clk, mod_drive_pos, mod_drive_neg;
	logic [31:0] rd;
	logic err;
	int n_errors = 0;
	int num_checks = 0;
	int n;
	int lo;

	// Pin level: our block when it drives, otherwise the outside world
	wire logic p2 = pin_oe_n[0] ? ext_lvl[0] : pin_out[0];
	wire logic p3 = pin_oe_n[1] ? ext_lvl[1] : pin_out[1];
	wire logic p4 = pin_oe_n[2] ? ext_lvl[2] : pin_out[2];

	// 20 MHz clock
	always #25 pclk = ~pclk;

	respiration_excitation_ctrl dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gp_is_input(gp_is_input),
		.gp_data(gp_data), .aux_pin_2_in(p2), .aux_pin_2_out(pin_out[0]),
		.aux_pin_2_oe_n(pin_oe_n[0]), .aux_pin_3_in(p3), .aux_pin_3_out(pin_out[1]),
		.aux_pin_3_oe_n(pin_oe_n[1]), .aux_pin_4_in(p4), .aux_pin_4_out(pin_out[2]),
		.aux_pin_4_oe_n(pin_oe_n[2]), .gp_level(gp_level),
		.gpio_pins_free(gpio_pins_free), .demod_enable_ch1(demod_enable_ch1),
		.mod_enable_ch1(mod_enable_ch1), .mod_clk(mod_clk), .demod_clk(demod_clk),
		.mod_drive_pos(mod_drive_pos), .mod_drive_neg(mod_drive_neg)
	);

	// ----------------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; an idle edge after it keeps psel from being set twice per step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic probe(input int s);
		case (s)
			0: return mod_clk;
			1: return pin_out[1];
			default: return demod_clk;
		endcase
	endfunction

	// Bounded wait for a level; n counts the edges spent
	task wait_lvl(input int s, input logic v);
		n = 0;
		while (probe(s) !== v) begin
			@(posedge pclk);
			n++;
			if (n > 45000) begin
				n_errors++;
				summarize();
			end
		end
	endtask

	// High time of a wave in clock cycles, within a tolerance band
	task half_chk(input int s, input int exp_lo, input int exp_hi);
		wait_lvl(s, 1'b0);
		wait_lvl(s, 1'b1);
		wait_lvl(s, 1'b0);
		chk(n >= exp_lo && n <= exp_hi, 1'b1);
	endtask

	// ----------------------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h58, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h5c, 32'h0);
		chk(rd, 32'h0);
		chk(gpio_pins_free, 1'b1);
		$display("test reset values done");

		// Enable bits each alone; upper write bits must be dropped
		apb(1'b1, 8'h58, 32'hffff_ff80);
		apb(1'b0, 8'h58, 32'h0);
		chk(rd, 32'h80);
		chk({demod_enable_ch1, mod_enable_ch1}, 2'b10);
		n = 0;
		repeat (400) begin
			@(posedge pclk);
			if (mod_clk !== 1'b0) n++;
		end
		chk(n, 0);
		apb(1'b1, 8'h58, 32'h40);
		chk({demod_enable_ch1, mod_enable_ch1}, 2'b01);
		apb(1'b1, 8'h60, 32'hff);
		apb(1'b0, 8'h60, 32'h0);
		chk({rd, err}, {32'h0, 1'b1});
		$display("test register access done");

		// Modulation clock rates in internal mode
		apb(1'b1, 8'h58, 32'hc2);
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, 8'h5c, 32'(f << 5));
			lo = 156 << f;
			half_chk(0, lo, lo + 1);
			chk({mod_drive_pos, mod_drive_neg}, {mod_clk, ~mod_clk});
		end
		$display("test modulation clock done");

		// Demodulation lag per phase code at 64 kHz
		apb(1'b1, 8'h5c, 32'h0);
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, 8'h58, 32'(8'hc2 | (p << 2)));
			if (p < 7) begin
				wait_lvl(0, 1'b0);
				wait_lvl(0, 1'b1);
				wait_lvl(2, 1'b1);
				lo = (p + 1) * 3125 / 160;
				chk(n >= lo - 3 && n <= lo + 3, 1'b1);
			end else begin
				n = 0;
				repeat (400) begin
					@(posedge pclk);
					if (demod_clk !== 1'b0) n++;
				end
				chk(n, 0);
			end
		end
		$display("test phase done");

		// Square waves override pins configured as inputs
		apb(1'b1, 8'h58, 32'hc2);
		for (int f = 2; f < 8; f++) begin
			apb(1'b1, 8'h5c, 32'(f << 5));
			// Pin mux lags the register by one edge
			@(posedge pclk);
			chk(pin_oe_n[2:1], 2'b00);
			lo = 625 << (f - 2);
			// 1 kHz period skipped to stay within the cycle budget
			if (f != 6) half_chk(1, lo - 2, lo + 2);
			chk(pin_out[2], !pin_out[1]);
			chk(mod_clk, 1'b0);
		end
		$display("test square waves done");

		// Mode none: pins back under general-purpose control; modes 01 and 11 withhold them
		gp_is_input <= 3'b010;
		gp_data <= 3'b001;
		ext_lvl <= 3'b010;
		apb(1'b1, 8'h58, 32'hc0);
		repeat (3) @(posedge pclk);
		chk(pin_oe_n, 3'b010);
		chk({pin_out[2], pin_out[0]}, 2'b01);
		chk(gp_level, 3'b011);
		for (int m = 1; m < 4; m += 2) begin
			apb(1'b1, 8'h58, 32'(8'hc0 | m));
			repeat (3) @(posedge pclk);
			chk({pin_oe_n, gp_level, gpio_pins_free}, {3'b111, 3'b000, 1'b0});
		end
		$display("test pin ownership done");

		// Reset in mid-run clears the registers again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h58, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h5c, 32'h0);
		chk(rd, 32'h0);
		$display("test second reset done");
		summarize();
	end
endmodule
